//--- verilog/dcf_fifo.sv
// Dual-clock 18-bit wide buffer with mode, offsets and status flags
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo
    import dcf_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic sys_rst,
    // Writer pins
    input wire logic write_clk,
    input wire logic [DATA_W-1:0] data_in_bus,
    input wire logic write_enable_n,
    input wire logic serial_load_en_n,
    // Reader pins
    input wire logic read_clk,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic retransmit_req_n,
    // Control pins
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic offset_load_sel_n,
    input wire logic fall_through_or_serial_in,
    input wire logic dont_care_tie,
    // Data out, three-state as value plus drive enable
    output logic [DATA_W-1:0] data_out_bus,
    output logic data_out_drive,
    // Flags, active low
    output logic full_flag_in_space_n,
    output logic empty_flag_out_valid_n,
    output logic almost_full_flag_n,
    output logic almost_empty_flag_n,
    output logic half_full_flag_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    dcf_pins_s pin_in;
    dcf_pins_s pin_s1;
    dcf_pins_s pin_s2;
    dcf_pins_s pin_s3;

    assign pin_in = '{write_clk: write_clk, read_clk: read_clk,
        data_in_bus: data_in_bus, write_enable_n: write_enable_n,
        read_enable_n: read_enable_n, serial_load_en_n: serial_load_en_n,
        offset_load_sel_n: offset_load_sel_n,
        fall_through_or_serial_in: fall_through_or_serial_in,
        master_reset_n: master_reset_n, partial_reset_n: partial_reset_n,
        retransmit_req_n: retransmit_req_n,
        output_enable_n: output_enable_n};

    // Two-stage capture plus a delay stage for edges
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    wire logic wr_rise;
    wire logic rd_rise;
    wire logic rd_turn;
    assign wr_rise = pin_s2.write_clk & ~pin_s3.write_clk;
    assign rd_rise = pin_s2.read_clk & ~pin_s3.read_clk;
    assign rd_turn = pin_s2.read_clk ^ pin_s3.read_clk;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [DATA_W-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [DATA_W-1:0] out_word;
    logic fall_through_mode;
    logic serial_mode;
    logic [OFS_W-1:0] empty_ofs;
    logic [OFS_W-1:0] full_ofs;
    logic wr_ofs_sel;
    logic rd_ofs_sel;
    logic rewind_hold;
    dcf_ft_e ft_state;
    logic [1:0] ft_count;

    // Both pointers live in one domain, so the count is coherent
    wire logic [PTR_W-1:0] word_count;
    assign word_count = wr_ptr - rd_ptr;

    wire logic is_full;
    wire logic is_empty;
    assign is_full = (word_count == DEPTH);
    assign is_empty = (word_count == 16'h0000);

    // Decoded requests, pins as seen after synchronisation
    wire logic in_master_rst;
    wire logic in_partial_rst;
    wire logic load_sel;
    wire logic mem_write;
    wire logic ofs_write;
    wire logic ser_shift;
    wire logic ofs_read;
    wire logic rd_req;
    wire logic do_rewind;
    assign in_master_rst = ~pin_s2.master_reset_n;
    assign in_partial_rst = ~pin_s2.partial_reset_n;
    assign load_sel = ~pin_s2.offset_load_sel_n;
    assign mem_write = wr_rise & ~pin_s2.write_enable_n & ~load_sel
        & ~is_full;
    assign ofs_write = wr_rise & ~pin_s2.write_enable_n & load_sel
        & ~serial_mode;
    assign ser_shift = wr_rise & ~pin_s2.serial_load_en_n & load_sel
        & serial_mode;
    assign ofs_read = rd_rise & ~pin_s2.read_enable_n & load_sel;
    assign rd_req = rd_rise & ~pin_s2.read_enable_n & ~load_sel;
    assign do_rewind = rd_rise & ~pin_s2.retransmit_req_n;

    // Next word and offset as an 18-bit output value
    wire logic [DATA_W-1:0] head_word;
    wire logic [DATA_W-1:0] ofs_word;
    assign head_word = mem[rd_ptr[ADDR_W-1:0]];
    assign ofs_word = {3'h0, rd_ofs_sel ? full_ofs : empty_ofs};

    ////////////////////////////////////////////////////////////////////////
    // Memory array, written only when space remains

    always_ff @(posedge clock)
    begin
        if (mem_write)
        begin
            mem[wr_ptr[ADDR_W-1:0]] <= pin_s2.data_in_bus;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode and offset registers

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            fall_through_mode <= 1'b0;
            serial_mode <= 1'b0;
            empty_ofs <= DEF_OFS_PAR;
            full_ofs <= DEF_OFS_PAR;
            wr_ofs_sel <= 1'b0;
        end
        else if (in_master_rst)
        begin
            fall_through_mode <=
                pin_s2.fall_through_or_serial_in;
            serial_mode <= ~load_sel;
            empty_ofs <= load_sel ? DEF_OFS_PAR : DEF_OFS_SER;
            full_ofs <= load_sel ? DEF_OFS_PAR : DEF_OFS_SER;
            wr_ofs_sel <= 1'b0;
        end
        else if (in_partial_rst)
        begin
            wr_ofs_sel <= 1'b0;
        end
        else if (ofs_write)
        begin
            if (wr_ofs_sel)
            begin
                full_ofs <= pin_s2.data_in_bus[OFS_W-1:0];
            end
            else
            begin
                empty_ofs <= pin_s2.data_in_bus[OFS_W-1:0];
            end
            wr_ofs_sel <= ~wr_ofs_sel;
        end
        else if (ser_shift)
        begin
            // Serial bit enters full offset LSB, chain runs empty then full
            {empty_ofs, full_ofs} <= {empty_ofs[OFS_W-2:0], full_ofs,
                pin_s2.fall_through_or_serial_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write pointer

    always_ff @(posedge clock)
    begin
        if (sys_rst || in_master_rst || in_partial_rst)
        begin
            wr_ptr <= '0;
        end
        else if (mem_write)
        begin
            wr_ptr <= wr_ptr + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read pointer, output register and fall-through sequencing

    always_ff @(posedge clock)
    begin
        if (sys_rst || in_master_rst || in_partial_rst)
        begin
            rd_ptr <= '0;
            out_word <= '0;
            rd_ofs_sel <= 1'b0;
            rewind_hold <= 1'b0;
            ft_state <= DCF_FT_EMPTY;
            ft_count <= 2'h0;
        end
        else if (do_rewind)
        begin
            // Rewind to first location, writer side untouched
            rd_ptr <= {wr_ptr[PTR_W-1], {ADDR_W{1'b0}}};
            rewind_hold <= 1'b1;
            ft_state <= DCF_FT_EMPTY;
            ft_count <= 2'h0;
        end
        else if (ofs_read)
        begin
            out_word <= ofs_word;
            rd_ofs_sel <= ~rd_ofs_sel;
            rewind_hold <= 1'b0;
        end
        else if (!fall_through_mode)
        begin
            if (rd_rise)
            begin
                rewind_hold <= 1'b0;
            end
            if (rd_req && !is_empty)
            begin
                out_word <= head_word;
                rd_ptr <= rd_ptr + 16'h0001;
            end
        end
        else
        begin
            if (rd_rise)
            begin
                rewind_hold <= 1'b0;
            end
            case (ft_state)
                DCF_FT_EMPTY:
                begin
                    if (!is_empty)
                    begin
                        ft_state <= DCF_FT_WAIT;
                        ft_count <= 2'h0;
                    end
                end
                DCF_FT_WAIT:
                begin
                    // Count read clock transitions, then fall through
                    if (rd_turn)
                    begin
                        if (ft_count == FALL_THRU_EDGES - 2'h1)
                        begin
                            out_word <= head_word;
                            rd_ptr <= rd_ptr + 16'h0001;
                            ft_state <= DCF_FT_VALID;
                        end
                        ft_count <= ft_count + 2'h1;
                    end
                end
                DCF_FT_VALID:
                begin
                    if (rd_req)
                    begin
                        if (!is_empty)
                        begin
                            out_word <= head_word;
                            rd_ptr <= rd_ptr + 16'h0001;
                        end
                        else
                        begin
                            ft_state <= DCF_FT_EMPTY;
                        end
                    end
                end
                default:
                begin
                    ft_state <= DCF_FT_EMPTY;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and flags

    wire logic out_ready;
    assign out_ready = (ft_state == DCF_FT_VALID) & ~rewind_hold;

    // Value held in flops, driven only while enabled
    assign data_out_bus = data_out_drive ? out_word : '0;
    assign data_out_drive = ~pin_s2.output_enable_n;

    assign full_flag_in_space_n = fall_through_mode ? is_full
        : ~is_full;
    assign empty_flag_out_valid_n = fall_through_mode ? ~out_ready
        : ~(is_empty | rewind_hold);
    assign almost_full_flag_n = ~(word_count
        > (DEPTH - {1'b0, full_ofs}));
    assign almost_empty_flag_n = ~(word_count
        < {1'b0, empty_ofs});
    assign half_full_flag_n = ~(word_count > HALF_DEPTH);

endmodule : dcf_fifo

`default_nettype wire

//--- shared/dcf_pkg.sv
// Constants and types shared by the dual-clock buffer with flags
// Operation
// - Both data buses are eighteen bits wide
// - Master reset zeroes pointers and output register
// - Master reset latches mode, default offset, method
// - Partial reset zeroes pointers and output register
// - Partial reset keeps mode, method and offsets
// - Retransmit rewinds read pointer, forces empty briefly
// - Mode pin at reset, serial bit afterwards
// - Write enable stores word or parallel offset
// - Serial enable shifts one offset bit per edge
// - Read enable presents next word or offset
// - Data outputs driven only while output enable low
// - Load pin picks default, then gates offsets
// - Full pin means full or input ready
// - Empty pin means empty or output ready
// - Almost-full low above capacity minus offset
// - Almost-empty low below empty offset
// - Half-full shows count against half capacity
// - Fall-through first word after three read transitions
// - Default 127 parallel, default 1023 serial
// - Serial load needs serial enable and load
package dcf_pkg;

    localparam int DATA_W = 18;
    localparam int ADDR_W = 15;
    localparam int PTR_W = 16;
    localparam int OFS_W = 15;
    localparam logic [PTR_W-1:0] DEPTH = 16'h8000;
    localparam logic [PTR_W-1:0] HALF_DEPTH = 16'h4000;
    localparam logic [OFS_W-1:0] DEF_OFS_PAR = 15'h007f;
    localparam logic [OFS_W-1:0] DEF_OFS_SER = 15'h03ff;
    localparam logic [1:0] FALL_THRU_EDGES = 2'h3;

    // Fall-through output register states
    typedef enum logic [1:0] {
        DCF_FT_EMPTY = 2'b00,
        DCF_FT_WAIT = 2'b01,
        DCF_FT_VALID = 2'b10
    } dcf_ft_e;

    // Every pin input except dont_care_tie, sampled together
    typedef struct packed {
        logic write_clk;
        logic read_clk;
        logic [DATA_W-1:0] data_in_bus;
        logic write_enable_n;
        logic read_enable_n;
        logic serial_load_en_n;
        logic offset_load_sel_n;
        logic fall_through_or_serial_in;
        logic master_reset_n;
        logic partial_reset_n;
        logic retransmit_req_n;
        logic output_enable_n;
    } dcf_pins_s;

endpackage : dcf_pkg

//--- tb/dcf_fifo_asserts.sv
// Pin-level checker for the dual-clock buffer
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_chk
    import dcf_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic sys_rst,
    // Control pins
    input wire logic read_clk,
    input wire logic retransmit_req_n,
    input wire logic output_enable_n,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic fall_through_or_serial_in,
    // Data and flags
    input wire logic [DATA_W-1:0] data_out_bus,
    input wire logic data_out_drive,
    input wire logic full_flag_in_space_n,
    input wire logic empty_flag_out_valid_n,
    input wire logic almost_full_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic half_full_flag_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic ft_mode;
    // Mode strap seen while master reset is low
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            ft_mode <= 1'b0;
        else if (!master_reset_n)
            ft_mode <= fall_through_or_serial_in;
    end
    ////////////////////////////////////////////////////////////////////
    a_idle_bus_zero:
        assert property (!data_out_drive |-> data_out_bus == '0)
        else $error("bus not zero while undriven");
    a_oe_off_release:
        assert property (output_enable_n [*4] |-> !data_out_drive)
        else $error("bus driven with output enable off");
    a_oe_on_drive:
        assert property (!output_enable_n [*4] |-> data_out_drive)
        else $error("bus undriven with output enable on");
    a_mrst_out_zero:
        assert property (!master_reset_n [*4] |-> data_out_bus == '0)
        else $error("output not zero in master reset");
    a_prst_out_zero:
        assert property (!partial_reset_n [*4] |-> data_out_bus == '0)
        else $error("output not zero in partial reset");
    a_mrst_flag_set:
        assert property ($rose(master_reset_n) |-> ##2
            full_flag_in_space_n != ft_mode && !almost_empty_flag_n &&
            empty_flag_out_valid_n == ft_mode && half_full_flag_n)
        else $error("flags wrong after master reset");
    a_prst_flag_set:
        assert property ($rose(partial_reset_n) |-> ##2
            empty_flag_out_valid_n == ft_mode && almost_full_flag_n &&
            full_flag_in_space_n != ft_mode && half_full_flag_n)
        else $error("flags wrong after partial reset");
    a_rewind_force_empty:
        assert property ($rose(read_clk) && !retransmit_req_n &&
            master_reset_n && partial_reset_n |->
            ##5 empty_flag_out_valid_n == ft_mode)
        else $error("retransmit did not force empty");
    // Main scenarios reached
    c_retransmit: cover property ($rose(read_clk) && !retransmit_req_n);
    c_fall_thru: cover property (ft_mode && $fell(empty_flag_out_valid_n));
    c_oe_off: cover property ($fell(data_out_drive));
endmodule : dcf_fifo_chk

bind dcf_fifo dcf_fifo_chk dcf_fifo_chk_inst (
    .clock, .sys_rst, .read_clk, .retransmit_req_n, .output_enable_n,
    .master_reset_n, .partial_reset_n, .fall_through_or_serial_in,
    .data_out_bus, .data_out_drive, .full_flag_in_space_n,
    .empty_flag_out_valid_n, .almost_full_flag_n, .almost_empty_flag_n,
    .half_full_flag_n
);

`default_nettype wire

//--- tb/dcf_far_end.sv
// Writer and reader logic driving the buffer pins
`timescale 1ns/1ps
`default_nettype none

module dcf_far_end
    import dcf_pkg::*;
(
    // System
    input wire logic clock,
    // Writer side
    output logic write_clk,
    output logic [DATA_W-1:0] data_in_bus,
    output logic write_enable_n,
    output logic serial_load_en_n,
    output logic fall_through_or_serial_in,
    // Reader side
    output logic read_clk,
    output logic read_enable_n,
    output logic retransmit_req_n
);
    // Idle levels
    initial
    begin
        write_clk = 1'b0;
        read_clk = 1'b0;
        data_in_bus = '0;
        write_enable_n = 1'b1;
        serial_load_en_n = 1'b1;
        read_enable_n = 1'b1;
        retransmit_req_n = 1'b1;
        fall_through_or_serial_in = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold
    // Mode strap level
    task automatic strap(input logic m);
        fall_through_or_serial_in <= m;
    endtask : strap
    // One write-clock pulse: word store or serial shift
    task automatic wr_cyc(input logic [DATA_W-1:0] d, input logic ser);
        data_in_bus <= d;
        fall_through_or_serial_in <= d[0];
        write_enable_n <= ser;
        serial_load_en_n <= !ser;
        hold(3);
        write_clk <= 1'b1;
        hold(4);
        write_clk <= 1'b0;
        hold(4);
        data_in_bus <= ~d;
        fall_through_or_serial_in <= ~d[0];
        write_enable_n <= 1'b1;
        serial_load_en_n <= 1'b1;
        hold(1);
        #1;
    endtask : wr_cyc
    // One read-clock pulse: read, or retransmit when rewind is set
    task automatic rd_cyc(input logic rewind);
        read_enable_n <= rewind;
        retransmit_req_n <= !rewind;
        hold(3);
        read_clk <= 1'b1;
        hold(5);
        read_clk <= 1'b0;
        read_enable_n <= 1'b1;
        retransmit_req_n <= 1'b1;
        hold(4);
        #1;
    endtask : rd_cyc
    // Bare read-clock transition with no enable
    task automatic tog();
        read_clk <= !read_clk;
        hold(5);
        #1;
    endtask : tog
endmodule : dcf_far_end

`default_nettype wire

//--- tb/dcf_fifo_tb.sv
// Self-checking bench for the dual-clock buffer
`timescale 1ns/1ps
`default_nettype none

module dcf_fifo_tb
    import dcf_pkg::*;
;
    logic clock, sys_rst, output_enable_n, offset_load_sel_n;
    logic master_reset_n, partial_reset_n, write_clk, read_clk;
    logic write_enable_n, serial_load_en_n, read_enable_n;
    logic retransmit_req_n, fall_through_or_serial_in, data_out_drive;
    logic [DATA_W-1:0] data_in_bus, data_out_bus;
    logic [4:0] flags; // full, empty, almost full, almost empty, half
    logic [DATA_W-1:0] words [3] = '{18'h2a5a5, 18'h15a5a, 18'h3c3c3};
    logic [29:0] chain = {15'h0002, 15'h0001};
    logic dont_care_level = 1'b0; // Fixed level for the whole run
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;

    dcf_fifo dcf_fifo_inst (
        .clock(clock), .sys_rst(sys_rst), .write_clk(write_clk),
        .data_in_bus(data_in_bus), .write_enable_n(write_enable_n),
        .serial_load_en_n(serial_load_en_n), .read_clk(read_clk),
        .read_enable_n(read_enable_n), .output_enable_n(output_enable_n),
        .retransmit_req_n(retransmit_req_n),
        .master_reset_n(master_reset_n), .partial_reset_n(partial_reset_n),
        .offset_load_sel_n(offset_load_sel_n),
        .fall_through_or_serial_in(fall_through_or_serial_in),
        .dont_care_tie(dont_care_level),
        .data_out_bus(data_out_bus), .data_out_drive(data_out_drive),
        .full_flag_in_space_n(flags[4]), .empty_flag_out_valid_n(flags[3]),
        .almost_full_flag_n(flags[2]), .almost_empty_flag_n(flags[1]),
        .half_full_flag_n(flags[0])
    );
    dcf_far_end dcf_far_end_inst (
        .clock(clock), .write_clk(write_clk), .data_in_bus(data_in_bus),
        .write_enable_n(write_enable_n),
        .serial_load_en_n(serial_load_en_n),
        .fall_through_or_serial_in(fall_through_or_serial_in),
        .read_clk(read_clk), .read_enable_n(read_enable_n),
        .retransmit_req_n(retransmit_req_n)
    );
    ////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #2 clock = ~clock;
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input logic [DATA_W-1:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Reset pin pulse, master or partial
    task automatic pulse(input logic mst);
        master_reset_n <= !mst;
        partial_reset_n <= mst;
        dcf_far_end_inst.hold(6);
        master_reset_n <= 1'b1;
        partial_reset_n <= 1'b1;
        dcf_far_end_inst.hold(4);
        #1;
    endtask : pulse
    // Read back empty then full offset
    task automatic rd_ofs(input logic [DATA_W-1:0] e, f);
        offset_load_sel_n <= 1'b0;
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(data_out_bus, e);
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(data_out_bus, f);
        offset_load_sel_n <= 1'b1;
    endtask : rd_ofs
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        sys_rst = 1'b1;
        output_enable_n = 1'b0;
        offset_load_sel_n = 1'b0;
        master_reset_n = 1'b1;
        partial_reset_n = 1'b1;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        dcf_far_end_inst.strap(1'b0);
        pulse(1'b1);
        chk(18'(flags), 18'h15);
        dcf_far_end_inst.wr_cyc(18'h3, 1'b0);
        dcf_far_end_inst.wr_cyc(18'h7fff, 1'b0);
        rd_ofs(18'h3, 18'h7fff);
        for (int i = 0; i < 3; i++)
            dcf_far_end_inst.wr_cyc(words[i], 1'b0);
        chk(18'(flags), 18'h1b);
        for (int i = 0; i < 3; i++)
        begin
            dcf_far_end_inst.rd_cyc(1'b0);
            chk(data_out_bus, words[i]);
            if (i == 0)
                chk(18'(flags), 18'h19);
        end
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(data_out_bus, words[2]);
        chk(18'(flags), 18'h15);
        dcf_far_end_inst.rd_cyc(1'b1);
        chk(18'(flags), 18'h13);
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(data_out_bus, words[0]);
        output_enable_n <= 1'b1;
        dcf_far_end_inst.hold(4);
        #1;
        chk(data_out_bus, '0);
        chk(18'(data_out_drive), 18'h0);
        output_enable_n <= 1'b0;
        pulse(1'b0);
        chk(18'(flags), 18'h15);
        rd_ofs(18'h3, 18'h7fff);
        // Standard mode, serial offsets
        dcf_far_end_inst.strap(1'b0);
        offset_load_sel_n <= 1'b1;
        pulse(1'b1);
        offset_load_sel_n <= 1'b0;
        for (int i = 29; i >= 0; i--)
            dcf_far_end_inst.wr_cyc(18'(chain[i]), 1'b1);
        rd_ofs(18'h2, 18'h1);
        // Fall-through mode
        dcf_far_end_inst.strap(1'b1);
        pulse(1'b1);
        offset_load_sel_n <= 1'b1;
        chk(18'(flags), 18'h0d);
        dcf_far_end_inst.wr_cyc(words[1], 1'b0);
        chk(18'(flags[3]), 18'h1);
        for (int i = 0; i < 3; i++)
            dcf_far_end_inst.tog();
        chk(18'(flags[3]), 18'h0);
        chk(data_out_bus, words[1]);
        // Later words wait for a read, then retransmit re-falls
        dcf_far_end_inst.tog();
        dcf_far_end_inst.wr_cyc(words[2], 1'b0);
        chk(data_out_bus, words[1]);
        chk(18'(flags[4]), 18'h0);
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(data_out_bus, words[2]);
        chk(18'(flags[3]), 18'h0);
        dcf_far_end_inst.rd_cyc(1'b0);
        chk(18'(flags[3]), 18'h1);
        chk(data_out_bus, words[2]);
        dcf_far_end_inst.rd_cyc(1'b1);
        chk(18'(flags[3]), 18'h1);
        dcf_far_end_inst.tog();
        dcf_far_end_inst.tog();
        chk(18'(flags[3]), 18'h0);
        chk(data_out_bus, words[1]);
        give_verdict();
    end
endmodule : dcf_fifo_tb

`default_nettype wire
